// file: core/pbs_sram.sv
`timescale 1ns/1ps
`default_nettype none
`include "pbs_defines.svh"

module pbs_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = `PBS_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [0:DEPTH-1];
  logic [PW:0] wr_ptr_reg;
  logic [PW:0] rd_ptr_reg;
  logic full;
  logic empty;
  logic push;
  logic pop;

  // Extra pointer bit tells full from empty
  assign empty = (wr_ptr_reg == rd_ptr_reg);
  assign full = (wr_ptr_reg[PW] != rd_ptr_reg[PW]) &&
                (wr_ptr_reg[PW-1:0] == rd_ptr_reg[PW-1:0]);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = store[rd_ptr_reg[PW-1:0]];
  assign push = in_valid && !full;
  assign pop = out_ready && !empty;

  always_ff @(posedge clk) begin
    if (push) begin
      store[wr_ptr_reg[PW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_ptr_reg <= '0;
    end else if (push) begin
      wr_ptr_reg <= wr_ptr_reg + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_ptr_reg <= '0;
    end else if (pop) begin
      rd_ptr_reg <= rd_ptr_reg + 1'b1;
    end
  end

endmodule // pbs_fifo

module pbs_sram
  import pbs_pkg::*;
#(
  parameter int ADDR_W = `PBS_ADDR_W,
  parameter int LANES = `PBS_LANES,
  parameter int FIFO_DEPTH = `PBS_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clock_gate_n,
  input wire logic rw_sel,
  input wire logic chip_sel1_n,
  input wire logic chip_sel2,
  input wire logic chip_sel3_n,
  input wire logic burst_step_or_fetch,
  input wire logic [`PBS_BW_W-1:0] byte_lane_write_n,
  input wire logic burst_order_sel,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [LANES*`PBS_LANE_W-1:0] data_in,
  output logic [LANES*`PBS_LANE_W-1:0] data_out,
  output logic data_oe,
  output logic trace_valid,
  input wire logic trace_ready,
  output logic [LANES*`PBS_LANE_W-1:0] trace_data
);
  localparam int DW = LANES * `PBS_LANE_W;
  localparam int CW = `PBS_CNT_W;

  logic [DW-1:0] mem [0:(2**ADDR_W)-1];

  logic run;
  logic selected;
  logic do_load;
  logic do_step;
  logic fifo_in_ready;
  logic [CW-1:0] step_cnt;
  logic [CW-1:0] step_low;

  logic burst_active_reg;
  logic burst_write_reg;
  logic [CW-1:0] burst_base_reg;
  logic [CW-1:0] burst_cnt_reg;
  logic [ADDR_W-1:CW] burst_upper_reg;

  pbs_op_type s1_op_reg;
  pbs_op_type s1_op_next;
  logic [ADDR_W-1:0] s1_addr_reg;
  logic [ADDR_W-1:0] s1_addr_next;
  logic [LANES-1:0] s1_lanes_n_reg;
  pbs_op_type s2_op_reg;
  logic [ADDR_W-1:0] s2_addr_reg;
  logic [LANES-1:0] s2_lanes_n_reg;

  logic [DW-1:0] data_out_reg;
  logic data_oe_reg;

  // A full trace buffer freezes the part exactly like the clock gate,
  // so no read word is ever dropped; keep trace_ready high for timing
  assign run = !clock_gate_n && fifo_in_ready;
  assign selected = !chip_sel1_n && chip_sel2 && !chip_sel3_n;
  assign do_load = !burst_step_or_fetch;
  assign do_step = burst_step_or_fetch && burst_active_reg;

  assign step_cnt = burst_cnt_reg + `PBS_CNT_ONE;
  always_comb begin
    if (burst_order_sel == `PBS_ORDER_INTERLEAVED) begin
      step_low = burst_base_reg ^ step_cnt;
    end else begin
      step_low = burst_base_reg + step_cnt;
    end
  end

  // Command decode into the first pipeline stage
  always_comb begin
    s1_op_next = PBS_OP_NONE;
    s1_addr_next = s1_addr_reg;
    if (do_load && selected) begin
      s1_op_next = rw_sel ? PBS_OP_READ : PBS_OP_WRITE;
      s1_addr_next = addr;
    end else if (do_step) begin
      // Direction comes from the load, never from rw_sel here
      s1_op_next = burst_write_reg ? PBS_OP_WRITE : PBS_OP_READ;
      s1_addr_next = {burst_upper_reg, step_low};
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      burst_active_reg <= 1'b0;
    end else if (run) begin
      if (do_load) begin
        burst_active_reg <= selected;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      burst_write_reg <= 1'b0;
      burst_base_reg <= `PBS_CNT_ZERO;
      burst_upper_reg <= '0;
    end else if (run && do_load && selected) begin
      burst_write_reg <= !rw_sel;
      burst_base_reg <= addr[CW-1:0];
      burst_upper_reg <= addr[ADDR_W-1:CW];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      burst_cnt_reg <= `PBS_CNT_ZERO;
    end else if (run) begin
      if (do_load && selected) begin
        burst_cnt_reg <= `PBS_CNT_ZERO;
      end else if (do_step) begin
        burst_cnt_reg <= step_cnt;
      end
    end
  end

  // Two stages give the fixed data latency with no dead cycles
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s1_op_reg <= PBS_OP_NONE;
      s1_addr_reg <= '0;
      s1_lanes_n_reg <= '1;
      s2_op_reg <= PBS_OP_NONE;
      s2_addr_reg <= '0;
      s2_lanes_n_reg <= '1;
    end else if (run) begin
      s1_op_reg <= s1_op_next;
      s1_addr_reg <= s1_addr_next;
      s1_lanes_n_reg <= byte_lane_write_n[LANES-1:0];
      s2_op_reg <= s1_op_reg;
      s2_addr_reg <= s1_addr_reg;
      s2_lanes_n_reg <= s1_lanes_n_reg;
    end
  end

  // Lanes are written together in one edge, each on its own enable
  always_ff @(posedge clk) begin
    if (run && s2_op_reg == PBS_OP_WRITE) begin
      for (int i = 0; i < LANES; i++) begin
        if (!s2_lanes_n_reg[i]) begin
          mem[s2_addr_reg][i*`PBS_LANE_W +: `PBS_LANE_W] <=
            data_in[i*`PBS_LANE_W +: `PBS_LANE_W];
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      data_out_reg <= '0;
    end else if (run && s2_op_reg == PBS_OP_READ) begin
      data_out_reg <= mem[s2_addr_reg];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      data_oe_reg <= 1'b0;
    end else if (run) begin
      data_oe_reg <= (s2_op_reg == PBS_OP_READ);
    end
  end

  assign data_out = data_out_reg;
  assign data_oe = data_oe_reg;

  pbs_fifo #(
    .WIDTH(DW),
    .DEPTH(FIFO_DEPTH)
  ) trace_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_valid(run && s2_op_reg == PBS_OP_READ),
    .in_ready(fifo_in_ready),
    .in_data(mem[s2_addr_reg]),
    .out_valid(trace_valid),
    .out_ready(trace_ready),
    .out_data(trace_data)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence load_rd_s;
    run && do_load && selected && rw_sel;
  endsequence

  sequence idle_cmd_s;
    run && ((do_load && !selected) ||
            (burst_step_or_fetch && !burst_active_reg));
  endsequence

  sequence two_runs_s;
    ##1 run ##1 run;
  endsequence

  read_latency_a:
    assert property (load_rd_s ##0 two_runs_s |=> data_oe &&
                     data_out == $past(mem[s2_addr_reg]))
    else $error("read data not driven two cycles after load");

  step_addr_a:
    assert property (run && do_step |=>
                     s1_addr_reg[ADDR_W-1:CW] == $past(burst_upper_reg))
    else $error("advance did not use internal address");

  step_dir_a:
    assert property (run && do_step |=> s1_op_reg ==
                     ($past(burst_write_reg) ? PBS_OP_WRITE : PBS_OP_READ))
    else $error("advance changed burst direction");

  load_dir_a:
    assert property (run && do_load && selected && !rw_sel |=>
                     burst_write_reg && s1_op_reg == PBS_OP_WRITE)
    else $error("write load did not fix write direction");

  idle_start_a:
    assert property (idle_cmd_s |=> s1_op_reg == PBS_OP_NONE)
    else $error("deselect or no-op started an access");

  idle_release_a:
    assert property (idle_cmd_s ##0 two_runs_s |=> !data_oe)
    else $error("bus not released after deselect");

  select_all_a:
    assert property (run && do_load && !(chip_sel2 && !chip_sel1_n &&
                     !chip_sel3_n) |=> !burst_active_reg)
    else $error("partial select accepted");

  suspend_hold_a:
    assert property (!run |=> $stable(data_oe) && $stable(s1_op_reg) &&
                     $stable(s2_op_reg) && $stable(burst_cnt_reg))
    else $error("state changed during suspend");

  reset_release_a:
    assert property (disable iff (1'b0) $past(sys_rst) |-> !data_oe)
    else $error("bus driven after reset edge");

  lane_write_a:
    assert property (run && s2_op_reg == PBS_OP_WRITE &&
                     !s2_lanes_n_reg[0] |=>
                     mem[$past(s2_addr_reg)][`PBS_LANE_W-1:0] ==
                     $past(data_in[`PBS_LANE_W-1:0]))
    else $error("enabled lane not written");

  order_inter_a:
    assert property (run && do_step &&
                     burst_order_sel == `PBS_ORDER_INTERLEAVED |=>
                     s1_addr_reg[CW-1:0] ==
                     ($past(burst_base_reg) ^ burst_cnt_reg))
    else $error("interleaved order wrong");

  order_linear_a:
    assert property (run && do_step &&
                     burst_order_sel != `PBS_ORDER_INTERLEAVED |=>
                     s1_addr_reg[CW-1:0] ==
                     CW'($past(burst_base_reg) + burst_cnt_reg))
    else $error("linear order wrong");

  cnt_wrap_a:
    assert property (run && do_step && burst_cnt_reg == `PBS_CNT_LAST |=>
                     burst_cnt_reg == `PBS_CNT_ZERO &&
                     s1_addr_reg[CW-1:0] == $past(burst_base_reg))
    else $error("counter did not wrap to start");

  back_to_back_a:
    assert property (run && s1_op_reg != PBS_OP_NONE |=>
                     s2_op_reg == $past(s1_op_reg))
    else $error("pipeline dropped a command");

  gate_block_a:
    assert property (clock_gate_n |=> $stable(s1_addr_reg) &&
                     $stable(burst_active_reg))
    else $error("gated edge changed command state");

  pend_finish_a:
    assert property (load_rd_s ##1 idle_cmd_s ##1 run |=> data_oe)
    else $error("pending read dropped after deselect");

endmodule // pbs_sram
`default_nettype wire

// file: core/pbs_defines.svh
// Functional notes
// - Data phase falls two cycles after command.
// - Step high advances counter, uses internal address.
// - Read/write select ignored on advance cycles.
// - Load cycle fixes direction of whole burst.
// - Deselect starts nothing; later advances are no-ops.
// - Bus released two cycles after deselect/no-op.
// - Selected only when all three selects active.
// - Clock gate high makes edge absent; trace buffer still drains.
// - Suspend holds pipeline, counter and bus state.
// - Outputs released from first edge onward.
// - Only enabled byte lanes written, reads ignore.
// - Any lane combination written together.
// - Narrow configuration has only lanes one, two.
// - Order high: start address XOR count.
// - Order low: start plus count modulo four.
// - Counter wraps to start after fourth address.
// - New command every cycle, no turnaround.
`ifndef PBS_DEFINES_SVH
`define PBS_DEFINES_SVH

`define PBS_ADDR_W 17
`define PBS_LANES 4
`define PBS_LANE_W 9
`define PBS_BW_W 4
`define PBS_CNT_W 2
`define PBS_CNT_LAST 2'h3
`define PBS_CNT_ONE 2'h1
`define PBS_CNT_ZERO 2'h0
`define PBS_ORDER_INTERLEAVED 1'b1
`define PBS_FIFO_DEPTH 8

`endif

// file: core/pbs_pkg.sv
package pbs_pkg;

  // Operation carried down the two-stage pipeline
  typedef enum logic [1:0] {
    PBS_OP_NONE  = 2'b00,
    PBS_OP_READ  = 2'b01,
    PBS_OP_WRITE = 2'b10
  } pbs_op_type;

endpackage

// file: test/pbs_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module pbs_master_model #(
  parameter int W = 36
) (
  input wire logic clk,
  input wire logic run,
  input wire logic wr_now,
  input wire logic [W-1:0] wdata,
  output logic [W-1:0] data_in
);
  logic [W:0] s1_reg;
  logic [W:0] s2_reg;
  initial begin
    s1_reg = '0;
    s2_reg = '0;
    data_in = '0;
  end
  // Suspended edges do not advance the write pipe
  always @(posedge clk) begin
    if (run) begin
      s1_reg <= {wr_now, wdata};
      s2_reg <= s1_reg;
    end
  end
  // Idle bus toggles so stale data never looks valid
  always @(negedge clk) begin
    data_in <= s2_reg[W] ? s2_reg[W-1:0] : ~data_in;
  end
endmodule // pbs_master_model
`default_nettype wire

// file: test/test_pipelined_burst_sram_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "pbs_defines.svh"
module test_pipelined_burst_sram_control
  import pbs_pkg::*;
;
  localparam int W = 36;
  logic clk, sys_rst, clock_gate_n, rw_sel, chip_sel1_n, chip_sel2;
  logic chip_sel3_n, step, ord, trace_ready, data_oe, trace_valid, wr_now;
  logic act, dir;
  logic [3:0] bw_n;
  logic [1:0] cnt;
  logic [16:0] addr, base;
  logic [W-1:0] data_in, data_out, trace_data, wdata;
  logic [W-1:0] mem [int];
  logic [W-1:0] e_d [3];
  logic e_oe [3];
  logic e_ck [3];
  int n_fail, cmp_count;
  pbs_sram u_dut (.clk(clk), .sys_rst(sys_rst), .clock_gate_n(clock_gate_n),
    .rw_sel(rw_sel), .chip_sel1_n(chip_sel1_n), .chip_sel2(chip_sel2),
    .chip_sel3_n(chip_sel3_n), .burst_step_or_fetch(step),
    .byte_lane_write_n(bw_n), .burst_order_sel(ord), .addr(addr),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .trace_valid(trace_valid), .trace_ready(trace_ready),
    .trace_data(trace_data));
  pbs_master_model #(.W(W)) u_model (.clk(clk), .run(~clock_gate_n),
    .wr_now(wr_now), .wdata(wdata), .data_in(data_in));
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  task complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task chk1(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task chkw(input logic [W-1:0] got, input logic [W-1:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task cmp_out;
    if (e_ck[2]) begin
      chk1(data_oe, e_oe[2]);
      if (e_oe[2]) begin
        chkw(data_out, e_d[2]);
        // A held-off trace buffer keeps its oldest word at the head
        if (trace_ready === 1'b1) chkw(trace_data, e_d[2]);
      end
    end
  endtask
  task issue(input logic st, input logic rw, input logic [2:0] sn,
             input logic [3:0] bw, input logic [16:0] a,
             input logic [W-1:0] wd);
    logic [16:0] cur;
    @(negedge clk);
    cmp_out();
    cur = a;
    if (!st) begin
      act = (sn == 3'h0);
      dir = rw;
      base = a;
      cnt = 2'h0;
    end else if (act) begin
      cnt = cnt + 2'h1;
      cur = {base[16:2], ord ? base[1:0] ^ cnt : base[1:0] + cnt};
    end
    if (act && !dir)
      for (int i = 0; i < 4; i++)
        if (!bw[i]) mem[cur][i*9+:9] = wd[i*9+:9];
    for (int i = 2; i > 0; i--) begin
      e_ck[i] = e_ck[i-1];
      e_oe[i] = e_oe[i-1];
      e_d[i] = e_d[i-1];
    end
    e_ck[0] = 1'b1;
    e_oe[0] = act && dir;
    e_d[0] = (act && dir) ? mem[cur] : '0;
    clock_gate_n = 0;
    step = st;
    rw_sel = rw;
    {chip_sel3_n, chip_sel2, chip_sel1_n} = {sn[2], ~sn[1], sn[0]};
    bw_n = bw;
    addr = a;
    wr_now = act && !dir;
    wdata = wd;
  endtask
  // Suspended edges carry a load-write to 5 that must leave no trace
  task hold(input int n);
    repeat (n) begin
      @(negedge clk);
      cmp_out();
      clock_gate_n = 1;
      step = 0;
      rw_sel = 0;
      {chip_sel3_n, chip_sel2, chip_sel1_n} = 3'h2;
      bw_n = 4'h0;
      addr = 17'h5;
    end
  endtask
  task t_lanes;
    for (int b = 0; b < 16; b++) begin
      issue(0, 0, 3'h0, 4'h0, 17'(16 + b), {4{9'h1a5}});
      issue(0, 0, 3'h0, 4'(b), 17'(16 + b), {4{9'h05a}});
      issue(0, 1, 3'h0, 4'h0, 17'(16 + b), '0);
    end
    repeat (3) issue(0, 1, 3'h1, 4'hf, 17'h0, '0);
    $display("done t_lanes");
  endtask
  task t_burst;
    logic [16:0] a;
    for (int o = 0; o < 2; o++)
      for (int s = 0; s < 4; s++) begin
        a = 17'(17'h100 + o * 32 + s * 8 + s);
        issue(0, 0, 3'h0, 4'h0, a, {4{o[0], s[1:0], 6'h15}});
        // Order flips only after the load, so the last advance keeps it
        ord = o[0];
        for (int i = 1; i < 6; i++) begin
          issue(1, 1, 3'h1, 4'h0, '0, {4{o[0], s[1:0], i[2:0], 3'h2}});
          if (i == 2) hold(2);
        end
        issue(0, 1, 3'h0, 4'h0, a, '0);
        for (int i = 1; i < 6; i++)
          issue(1, 0, 3'h0, 4'h0, '0, '0);
      end
    repeat (3) issue(0, 1, 3'h1, 4'hf, 17'h0, '0);
    $display("done t_burst");
  endtask
  task t_desel;
    issue(0, 0, 3'h0, 4'h0, 17'h40, 36'h9_8765_4321);
    for (int k = 0; k < 3; k++) begin
      issue(0, 1, 3'h0, 4'hf, 17'h40, '0);
      issue(0, 1, 3'(1 << k), 4'h0, 17'h40, '0);
      issue(1, 1, 3'h0, 4'h0, 17'h40, '0);
      issue(1, 0, 3'h0, 4'h0, 17'h40, '0);
    end
    repeat (3) issue(0, 1, 3'h1, 4'hf, 17'h0, '0);
    $display("done t_desel");
  endtask
  task t_suspend;
    issue(0, 0, 3'h0, 4'h0, 17'h5, 36'h1_2345_6789);
    issue(0, 1, 3'h0, 4'h0, 17'h5, '0);
    issue(0, 1, 3'h1, 4'hf, 17'h0, '0);
    hold(4);
    issue(0, 1, 3'h0, 4'h0, 17'h5, '0);
    repeat (3) issue(0, 1, 3'h1, 4'hf, 17'h0, '0);
    $display("done t_suspend");
  endtask
  // Full trace buffer stalls the device; words must drain in read order
  task t_fifo;
    int j;
    // One more edge drains the last word of the previous test
    @(negedge clk);
    trace_ready = 0;
    for (int i = 0; i < 8; i++) issue(0, 1, 3'h0, 4'h0, 17'(16 + i), '0);
    @(negedge clk);
    {chip_sel3_n, chip_sel2, chip_sel1_n} = 3'h3;
    step = 0;
    repeat (4) @(negedge clk);
    chk1(trace_valid, 1'b1);
    chk1(data_oe, 1'b1);
    chkw(data_out, mem[23]);
    trace_ready = 1;
    j = 0;
    repeat (12) begin
      if (trace_valid === 1'b1) begin
        chkw(trace_data, mem[16 + j]);
        j++;
      end
      @(negedge clk);
    end
    chk1(j == 8, 1'b1);
    $display("done t_fifo");
  endtask
  initial begin
    {sys_rst, clock_gate_n, rw_sel, chip_sel1_n, step, wr_now} = 6'h21;
    {chip_sel2, chip_sel3_n, ord, trace_ready} = 4'h3;
    bw_n = 4'hf;
    addr = '0;
    wdata = '0;
    {act, dir, cnt, base} = '0;
    n_fail = 0;
    cmp_count = 0;
    for (int i = 0; i < 3; i++) e_ck[i] = 0;
    repeat (6) begin
      @(negedge clk);
      chk1(data_oe, 1'b0);
    end
    sys_rst = 0;
    t_lanes();
    t_burst();
    t_desel();
    t_suspend();
    t_fifo();
    complete_run();
  end
  initial begin
    #2000000;
    n_fail++;
    complete_run();
  end
endmodule // test_pipelined_burst_sram_control
`default_nettype wire
